// [src/dpsc_params.svh]
// constants of the dual-port serial configuration block
// assumes a 250 MHz system clock; included by the top module only
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH

// word layout
`define DPSC_WORD_BITS 24
`define DPSC_CNT_LAST 5'h17
`define DPSC_CNT_ADDR_DONE 5'h07
`define DPSC_SUB1_BIT 7
`define DPSC_SUB0_BIT 6

// converter port registers
`define DPSC_REG_CTRL 8'h00
`define DPSC_CTRL_SRST_BIT 0
`define DPSC_CTRL_RDEN_BIT 1
`define DPSC_REG_DEMOD_DIS 8'h16
`define DPSC_DEMOD_DIS_BIT 0
`define DPSC_REG_TEST 8'h3B
`define DPSC_TEST_EN_BIT 9
`define DPSC_BUF_PWR_BIT 8
`define DPSC_REG_BUF_GAIN 8'h36
`define DPSC_FB_2K_CODE 5'h10

// demodulator port registers
`define DPSC_DREG_CTRL 6'h00

// reset values
`define DPSC_CONV_RESET 16'h0000
// idle pin levels {sclk, select, data, port, converter clock} held by the synchroniser in reset
`define DPSC_PIN_IDLE 5'h0A
`define DPSC_DEMOD_RESET 16'h0000

// timing
`define DPSC_CLK_NS 4
`define DPSC_CONV_IDLE_NS 2000
`define DPSC_CONV_IDLE_CYC ((`DPSC_CONV_IDLE_NS) / (`DPSC_CLK_NS))

`endif

// [src/dpsc_pkg.sv]
// types shared by the dual-port serial configuration block
// assumes dpsc_params.svh holds the numeric constants
package dpsc_pkg;
  typedef enum logic {DPSC_PORT_CONV, DPSC_PORT_DEMOD} dpsc_port_t;
  typedef enum logic {DPSC_FR_IDLE, DPSC_FR_ACTIVE} dpsc_frame_t;
  typedef logic [15:0] dpsc_word_t;
endpackage

// [src/dpsc_sync.sv]
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a level from outside the i_clock domain
`timescale 1ns/1ps
module dpsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clock) begin
    // reset to the pins' idle levels so no false select or edge follows reset
    if (i_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

// [src/dpsc_top.sv]
// serial configuration port with converter and demodulator register banks
// assumes all serial pins and the converter clock are asynchronous to i_clock
`timescale 1ns/1ps
`include "dpsc_params.svh"

// What this block does and what its controller must do
// R1 - shift serial bits only while select is low, on rising serial clock
// R2 - load the word on every 24th rising edge; discard trailing partial bits
// R3 - several words per select period; count groups of 24 from select falling
// R4 - word is 8-bit address then 16-bit data loaded into addressed register
// R5 - bits travel most significant first; address bit 7 comes first
// R6 - work from 20 MHz serial clock down to hertz, any duty cycle
// R7 - controller writes zeros into unused register bits
// R8 - port pin high or floating reaches converter port; low reaches demodulator
// R9 - with readback enabled, addressed cycle shifts out 16 stored bits
// R10 - controller samples readback on rising edge, or falling when fast
// R11 - readback enable stays writable in readback; clearing restores writes
// R12 - serial output driven only while readback enable is set
// R13 - demodulator enabled after reset; bit 0 of 0x16 disables it
// R14 - controller holds port pin and select low through demodulator cycles
// R15 - demodulator address: bit 7 subchip one, bit 6 subchip zero, 5:0 register
// R16 - subchip zero bit writes lower channels, subchip one upper; both allowed
// R17 - controller normally sets both subchip bits, except offset registers
// R18 - demodulator readback: enable both ports, then address target port-low
// R19 - during demodulator readback, writes leave the target unchanged
// R20 - controller leaves readback clearing converter first, then demodulator
// R21 - controller keeps converter clock running for demodulator access
// R22 - register 59 bits 9 and 8 drive test mode; 54 code 10H picks 2k
// R23 - controller derives serial clock from converter clock by integer divide
// R24 - soft reset bit restores defaults and self-clears; register 0 write-only
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter int CONV_IDLE_CYC = `DPSC_CONV_IDLE_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_clk,
  input wire logic i_serial_select_low,
  input wire logic i_serial_in_pin,
  input wire logic i_port_select_pin,
  input wire logic i_converter_clk,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  output logic o_demod_enable,
  output logic o_amp_test_en,
  output logic o_buffer_amp_on,
  output logic o_fb_2k_sel,
  output logic o_readout_en,
  output logic o_demod_readout_en
);
  localparam logic [11:0] IDLE_LIM = 12'(CONV_IDLE_CYC);

  // picks one demodulator bank for readback: subchip zero wins if both set
  function automatic logic bank_of(input logic [7:0] addr);
    bank_of = addr[`DPSC_SUB0_BIT] ? 1'b0 : 1'b1;
  endfunction

  // subchip write mask {upper, lower}
  function automatic logic [1:0] sub_mask(input logic [7:0] addr);
    sub_mask = {addr[`DPSC_SUB1_BIT], addr[`DPSC_SUB0_BIT]};
  endfunction

  logic [4:0] pins_s;
  logic sclk_s;
  logic sen_s;
  logic sdi_s;
  logic port_s;
  logic cclk_s;

  // every pin passes two flops before any logic looks at it
  dpsc_sync #(
    .WIDTH(5),
    .RST_VAL(`DPSC_PIN_IDLE)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_serial_clk, i_serial_select_low, i_serial_in_pin,
              i_port_select_pin, i_converter_clk}),
    .o_sync(pins_s)
  );
  assign {sclk_s, sen_s, sdi_s, port_s, cclk_s} = pins_s;

  dpsc_frame_t fr_q, fr_d;
  dpsc_port_t port_q, port_d;
  logic sclk_prev_q, sclk_prev_d;
  logic cclk_prev_q, cclk_prev_d;
  logic [4:0] cnt_q, cnt_d;
  logic [22:0] sh_q, sh_d;
  dpsc_word_t conv_q [256];
  dpsc_word_t conv_d [256];
  dpsc_word_t demod_q [2][64];
  dpsc_word_t demod_d [2][64];
  logic rd_en_q, rd_en_d;
  logic drd_en_q, drd_en_d;
  logic rd_act_q, rd_act_d;
  dpsc_word_t rd_sh_q, rd_sh_d;
  logic out_q, out_d;
  logic [11:0] idle_q, idle_d;

  logic sclk_rise;
  logic sclk_fall;
  logic sen_low;
  logic word_done;
  logic addr_done;
  logic demod_ok;
  dpsc_port_t port_now;
  logic [23:0] word_in;
  logic [7:0] addr_now;
  logic [7:0] w_addr;
  logic [1:0] w_mask;
  dpsc_word_t w_data;

  // edges are found by comparing against the previous synchronised level,
  // so any duty cycle works as long as each phase spans a few clocks
  assign sclk_rise = sclk_s & ~sclk_prev_q; // R6
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign sen_low = ~sen_s;
  assign word_done = sen_low & sclk_rise & (cnt_q == `DPSC_CNT_LAST); // R2
  assign addr_done = sen_low & sclk_rise & (cnt_q == `DPSC_CNT_ADDR_DONE);
  assign word_in = {sh_q, sdi_s}; // R5
  assign addr_now = word_in[7:0];
  assign w_addr = word_in[23:16]; // R4
  assign w_data = word_in[15:0];
  assign w_mask = sub_mask(w_addr); // R16
  // port chosen live for the first bit, then held for the whole frame
  assign port_now = (fr_q == DPSC_FR_IDLE) ? port_d : port_q;
  // demodulator bank needs it enabled and a running converter clock
  assign demod_ok = ~conv_q[`DPSC_REG_DEMOD_DIS][`DPSC_DEMOD_DIS_BIT]
                    & (idle_q < IDLE_LIM);

  // converter clock watchdog
  always_comb begin
    cclk_prev_d = cclk_s;
    if (cclk_s != cclk_prev_q) begin
      idle_d = '0;
    end else if (idle_q != 12'hFFF) begin
      idle_d = idle_q + 12'h001;
    end else begin
      idle_d = idle_q;
    end
  end

  // frame tracking and bit shifter
  always_comb begin
    fr_d = fr_q;
    port_d = port_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sclk_prev_d = sclk_s;
    case (fr_q)
      DPSC_FR_IDLE: begin
        cnt_d = '0;
        // pin high or floating (pulled high outside) reaches converter
        port_d = (port_s | sen_s) ? DPSC_PORT_CONV : DPSC_PORT_DEMOD; // R8
        if (sen_low) begin
          fr_d = DPSC_FR_ACTIVE;
        end
      end
      DPSC_FR_ACTIVE: begin
        if (!sen_low) begin
          fr_d = DPSC_FR_IDLE; // partial word simply forgotten R2
          cnt_d = '0; // R3
        end
      end
      default: begin
        fr_d = DPSC_FR_IDLE;
      end
    endcase
    if (sen_low && sclk_rise) begin
      sh_d = word_in[22:0]; // R1
      cnt_d = (cnt_q == `DPSC_CNT_LAST) ? 5'h00 : cnt_q + 5'h01; // R3
    end
  end

  // register banks, readback enables and soft reset
  always_comb begin
    conv_d = conv_q;
    demod_d = demod_q;
    rd_en_d = rd_en_q;
    drd_en_d = drd_en_q;
    if (word_done && port_now == DPSC_PORT_CONV) begin
      if (w_addr == `DPSC_REG_CTRL) begin
        if (w_data[`DPSC_CTRL_SRST_BIT]) begin
          // defaults everywhere; the reset bit itself is never stored
          for (int i = 0; i < 256; i++) begin
            conv_d[i] = `DPSC_CONV_RESET; // R24
          end
          for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 64; i++) begin
              demod_d[b][i] = `DPSC_DEMOD_RESET; // R13
            end
          end
          rd_en_d = 1'b0;
          drd_en_d = 1'b0;
        end else begin
          rd_en_d = w_data[`DPSC_CTRL_RDEN_BIT]; // R11
        end
      end else if (!rd_en_q) begin
        conv_d[w_addr] = w_data; // R4
      end
    end else if (word_done && port_now == DPSC_PORT_DEMOD && demod_ok) begin
      if (w_addr[5:0] == `DPSC_DREG_CTRL) begin
        drd_en_d = w_data[`DPSC_CTRL_RDEN_BIT]; // R18
      end else if (!drd_en_q) begin
        // either subchip alone or both at once
        for (int b = 0; b < 2; b++) begin
          if (w_mask[b]) begin
            demod_d[b][w_addr[5:0]] = w_data; // R15 R16
          end
        end
      end
    end
  end

  // readback shifter: loads once the address is in, moves on falling edges
  always_comb begin
    rd_act_d = rd_act_q;
    rd_sh_d = rd_sh_q;
    out_d = out_q;
    if (!sen_low || word_done) begin
      rd_act_d = 1'b0;
    end else if (addr_done) begin
      if (port_now == DPSC_PORT_CONV && rd_en_q) begin
        // register zero is write-only and reads as zero
        rd_sh_d = (addr_now == `DPSC_REG_CTRL) ? 16'h0000 : conv_q[addr_now]; // R9
        rd_act_d = 1'b1;
      end else if (port_now == DPSC_PORT_DEMOD && drd_en_q && demod_ok) begin
        rd_sh_d = demod_q[bank_of(addr_now)][addr_now[5:0]]; // R18
        rd_act_d = 1'b1;
      end
    end
    if (!sen_low) begin
      out_d = 1'b0;
    end else if (rd_act_q && sclk_fall) begin
      out_d = rd_sh_q[15]; // R9
      rd_sh_d = {rd_sh_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fr_q <= DPSC_FR_IDLE;
      port_q <= DPSC_PORT_CONV;
      sclk_prev_q <= 1'b0;
      cclk_prev_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      conv_q <= '{default: `DPSC_CONV_RESET};
      demod_q <= '{default: '{default: `DPSC_DEMOD_RESET}};
      rd_en_q <= 1'b0;
      drd_en_q <= 1'b0;
      rd_act_q <= 1'b0;
      rd_sh_q <= '0;
      out_q <= 1'b0;
      idle_q <= 12'hFFF;
    end else begin
      fr_q <= fr_d;
      port_q <= port_d;
      sclk_prev_q <= sclk_prev_d;
      cclk_prev_q <= cclk_prev_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      conv_q <= conv_d;
      demod_q <= demod_d;
      rd_en_q <= rd_en_d;
      drd_en_q <= drd_en_d;
      rd_act_q <= rd_act_d;
      rd_sh_q <= rd_sh_d;
      out_q <= out_d;
      idle_q <= idle_d;
    end
  end

  // outputs; the driver stays off unless converter readback is enabled
  assign o_serial_out_pin = out_q;
  assign o_serial_out_oe = rd_en_q; // R12
  assign o_readout_en = rd_en_q;
  assign o_demod_readout_en = drd_en_q;
  assign o_demod_enable = ~conv_q[`DPSC_REG_DEMOD_DIS][`DPSC_DEMOD_DIS_BIT]; // R13
  assign o_amp_test_en = conv_q[`DPSC_REG_TEST][`DPSC_TEST_EN_BIT]; // R22
  assign o_buffer_amp_on = conv_q[`DPSC_REG_TEST][`DPSC_BUF_PWR_BIT];
  assign o_fb_2k_sel = (conv_q[`DPSC_REG_BUF_GAIN][4:0] == `DPSC_FB_2K_CODE);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_conv_word;
    word_done && port_now == DPSC_PORT_CONV;
  endsequence

  sequence s_conv_plain_write;
    s_conv_word and (w_addr != `DPSC_REG_CTRL && !rd_en_q);
  endsequence

  a_idle_hold: assert property (!sen_low |=> cnt_q == 5'h00 && $stable(sh_q)) // R1
    else $error("shifter moved while select high");

  a_count_bound: assert property (cnt_q <= `DPSC_CNT_LAST) // R3
    else $error("bit counter beyond 23");

  a_word_wrap: assert property (word_done |=> cnt_q == 5'h00) // R2
    else $error("counter did not wrap after 24th edge");

  a_word_store: assert property (s_conv_plain_write |=> conv_q[$past(w_addr)] == $past(w_data)) // R4
    else $error("converter word not stored");

  a_read_blocks: assert property (s_conv_word and (w_addr != `DPSC_REG_CTRL && rd_en_q)
                                  |=> conv_q[$past(w_addr)] == $past(conv_q[w_addr])) // R11
    else $error("write landed during readback");

  a_soft_clear: assert property (s_conv_word and (w_addr == `DPSC_REG_CTRL
                                 && w_data[`DPSC_CTRL_SRST_BIT])
                                 |=> !rd_en_q && o_demod_enable && !o_amp_test_en) // R24
    else $error("soft reset left state behind");

  a_demod_off: assert property (s_conv_plain_write and (w_addr == `DPSC_REG_DEMOD_DIS)
                                |=> o_demod_enable == !$past(w_data[0])) // R13
    else $error("demodulator enable wrong after write");

  a_test_bits: assert property (s_conv_plain_write and (w_addr == `DPSC_REG_TEST)
                                |=> o_amp_test_en == $past(w_data[9])
                                    && o_buffer_amp_on == $past(w_data[8])) // R22
    else $error("test mode bits not applied");

  // the driver may only come on after a converter word that sets the readback bit
  a_oe_gate: assert property ($rose(o_serial_out_oe)
                              |-> $past(word_done && port_now == DPSC_PORT_CONV
                                        && w_addr == `DPSC_REG_CTRL
                                        && w_data[`DPSC_CTRL_RDEN_BIT])) // R12
    else $error("output driven without readback enable");

  a_demod_frozen: assert property (word_done && port_now == DPSC_PORT_DEMOD && drd_en_q
                                   && w_addr[5:0] != `DPSC_DREG_CTRL
                                   |=> demod_q[0][$past(w_addr[5:0])]
                                       == $past(demod_q[0][w_addr[5:0]])) // R19
    else $error("demodulator register changed in readback");
endmodule

// [tb/dpsc_ctrl_model.sv]
// controller model that drives the serial configuration pins of the block
// assumes the bench calls frame() and runs i_clock at 250 MHz
`timescale 1ns/1ps
module dpsc_ctrl_model (
  input wire logic i_clock,
  input wire logic i_serial_out_pin,
  output logic o_serial_clk,
  output logic o_serial_select_low,
  output logic o_serial_in_pin,
  output logic o_port_select_pin,
  output logic o_converter_clk
);
  logic [15:0] rd_q;
  logic [1:0] cc_q;

  // idle pins: clock parked low, select high, data at its pull-down level
  initial begin
    o_serial_clk = 1'b0;
    o_serial_select_low = 1'b1;
    o_serial_in_pin = 1'b0;
    o_port_select_pin = 1'b1;
    o_converter_clk = 1'b0;
    cc_q = 2'h0;
    rd_q = 16'h0000;
  end

  // converter clock never stops, so the demodulator port stays usable
  always @(posedge i_clock) begin
    cc_q <= cc_q + 2'h1;
    o_converter_clk <= cc_q[1];
  end

  // one select-low period: n bits, msb first, 8 i_clock per serial phase;
  // the serial period is four converter periods and toggles on the same edge
  task automatic frame(input logic port, input logic [47:0] bits, input int n,
                       input logic sel);
    @(posedge i_clock);
    o_port_select_pin <= port;
    @(posedge i_clock);
    o_serial_select_low <= ~sel;
    repeat (4) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      o_serial_in_pin <= bits[47 - i];
      repeat (8) @(posedge i_clock);
      o_serial_clk <= 1'b1;
      // 64 ns period, so the rising edge is a safe sampling point
      if ((i % 24) >= 8) rd_q = {rd_q[14:0], i_serial_out_pin};
      repeat (8) @(posedge i_clock);
      o_serial_clk <= 1'b0;
    end
    repeat (8) @(posedge i_clock);
    o_serial_select_low <= 1'b1;
    o_serial_in_pin <= 1'b0; // released line falls to its pull-down
    @(posedge i_clock);
    o_port_select_pin <= 1'b1; // floating port pin reads as converter port
    repeat (8) @(posedge i_clock);
  endtask
endmodule

// [tb/dpsc_top_tb.sv]
// self-checking bench for the dual-port serial configuration block
// assumes dpsc_top and the controller model dpsc_ctrl_model are compiled first
`timescale 1ns/1ps
module dpsc_top_tb;
  typedef struct packed {
    logic port;
    logic [23:0] word;
    logic [6:0] st;
  } dpsc_row_t;

  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic serial_clk, select_low, serial_in, port_sel, conv_clk;
  logic serial_out, serial_oe;
  logic [5:0] flags;
  int mismatches = 0;
  int tests_run = 0;
  // status = {oe, demod_en, test_en, buf_on, fb_2k, readout, demod_readout};
  // data words keep unused bits at zero
  dpsc_row_t rows [13] = '{
    '{1'b1, 24'h3B0300, 7'h38},
    '{1'b1, 24'h3B0200, 7'h30},
    '{1'b1, 24'h360010, 7'h34},
    '{1'b1, 24'h000001, 7'h20},
    '{1'b1, 24'h360011, 7'h20},
    '{1'b1, 24'h160001, 7'h00},
    '{1'b0, 24'hC00002, 7'h00},
    '{1'b1, 24'h160000, 7'h20},
    '{1'b1, 24'h3B0200, 7'h30},
    '{1'b0, 24'hC5A5A5, 7'h30},
    '{1'b0, 24'h855A5A, 7'h30},
    '{1'b0, 24'h000002, 7'h31},
    '{1'b1, 24'h000002, 7'h73}
  };

  // free-running system clock, 4 ns period
  always #2 i_clock = ~i_clock;

  dpsc_ctrl_model dpsc_ctrl_model_i (
    .i_clock(i_clock),
    .i_serial_out_pin(serial_out),
    .o_serial_clk(serial_clk),
    .o_serial_select_low(select_low),
    .o_serial_in_pin(serial_in),
    .o_port_select_pin(port_sel),
    .o_converter_clk(conv_clk)
  );

  dpsc_top dpsc_top_i (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_serial_clk(serial_clk),
    .i_serial_select_low(select_low),
    .i_serial_in_pin(serial_in),
    .i_port_select_pin(port_sel),
    .i_converter_clk(conv_clk),
    .o_serial_out_pin(serial_out),
    .o_serial_out_oe(serial_oe),
    .o_demod_enable(flags[5]),
    .o_amp_test_en(flags[4]),
    .o_buffer_amp_on(flags[3]),
    .o_fb_2k_sel(flags[2]),
    .o_readout_en(flags[1]),
    .o_demod_readout_en(flags[0])
  );

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one framed word, then the status pins
  task automatic wr(input logic p, input logic [23:0] w, input logic [15:0] exp);
    dpsc_ctrl_model_i.frame(p, {w, 24'h000000}, 24, 1'b1);
    chk({9'h000, serial_oe, flags}, exp);
  endtask

  // one readback frame, then the shifted-out value
  task automatic rd(input logic p, input logic [23:0] w, input logic [15:0] exp);
    dpsc_ctrl_model_i.frame(p, {w, 24'h000000}, 24, 1'b1);
    chk(dpsc_ctrl_model_i.rd_q, exp);
  endtask

  // reset held two cycles; synchronisers flush before the first frame
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk({9'h000, serial_oe, flags}, 16'h0020);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence: table rows, then readback and framing corner cases
  initial begin
    do_reset();
    for (int k = 0; k < 13; k++) begin
      wr(rows[k].port, rows[k].word, {9'h000, rows[k].st});
    end
    rd(1'b1, 24'h3BFFFF, 16'h0200);
    chk({9'h000, serial_oe, flags}, 16'h0073);
    rd(1'b0, 24'h451234, 16'hA5A5);
    rd(1'b0, 24'h850000, 16'h5A5A);
    rd(1'b0, 24'h450000, 16'hA5A5);
    wr(1'b1, 24'h000000, 16'h0031);
    wr(1'b0, 24'h000000, 16'h0030);
    wr(1'b1, 24'h3B0000, 16'h0020);
    dpsc_ctrl_model_i.frame(1'b1, {24'h3B0300, 24'h360010}, 48, 1'b1);
    chk({9'h000, serial_oe, flags}, 16'h003C);
    // trailing 20 bits are a soft-reset word cut short before its reset bit
    dpsc_ctrl_model_i.frame(1'b1, {24'h3B0000, 24'h000001}, 44, 1'b1);
    chk({9'h000, serial_oe, flags}, 16'h0024);
    dpsc_ctrl_model_i.frame(1'b1, {24'h3B0300, 24'h000000}, 24, 1'b0);
    chk({9'h000, serial_oe, flags}, 16'h0024);
    do_reset();
    summarize();
  end

  // watchdog sized well above the roughly 40 us the sequence needs
  initial begin
    #200000;
    mismatches++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end
endmodule
